// ===== rtl/sdx_cmd.sv
/*
 * Scratchpad command interpreter (write, read, copy with password) and its copy FIFO.
 * Assumes a slot engine on sys_clk giving write-slot, read-slot and bus-reset pulses,
 * sampling tx_bit on each read slot, and a memory port that may stall (mem_ready).
 */
// Overview of operation
// [RQ1] Master loads target address; device keeps it
// [RQ2] Low five status bits give ending offset
// [RQ3] Copy only runs when ending offset 1Fh
// [RQ4] Partial-byte flag at bit five
// [RQ5] Status bit six always reads zero
// [RQ6] Low address bits give scratchpad start offset
// [RQ7] Copy-accepted flag set by copy, write clears
// [RQ8] Write command 0Fh: address then data
// [RQ9] Incomplete trailing byte dropped, partial flag set
// [RQ10] Write CRC over command, address, data; inverted
// [RQ11] Read AAh sends address, status, scratchpad data
// [RQ12] Read ends with inverted CRC-16
// [RQ13] Ones after read CRC until reset
// [RQ14] Copy 99h: three-byte pattern, then password
// [RQ15] Wrong password: silent until reset
// [RQ16] Pattern match sets accepted flag, starts copy
// [RQ17] Alternating bits after copy until reset
// [RQ18] Reset ignored during copy; 2us per byte
// [RQ19] Copy start offset through ending offset
// [RQ20] Data and calibration pages always copyable
// [RQ21] Mission blocks register-page copies, flag stays zero
// [RQ22] Standard speed unless fast speed selected
// [RQ23] Mission sampling accesses take memory priority
// [RQ24] Password arrives bit 0 first
// [RQ25] CRC polynomial x16+x15+x2+1, LSB first
`timescale 1ns/10ps

module sdx_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH]; // Storage words
	logic [AW-1:0] wr_ptr; // Next word to fill
	logic [AW-1:0] rd_ptr; // Next word to drain
	logic [AW:0] count; // Words held, one bit wider for full
	logic push;
	logic pop;

	assign in_ready = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];
	assign push = ce && in_valid && in_ready;
	assign pop = ce && out_valid && out_ready;

	// Storage write
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// Pointers and fill level
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			// Simultaneous push and pop leave the level unchanged
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule : sdx_fifo

module sdx_cmd
	import sdx_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic slot_write,
	input wire logic slot_bit,
	input wire logic slot_read,
	input wire logic bus_reset,
	output logic tx_bit,
	output logic reset_blocked,
	input wire logic fast_speed_select,
	output logic fast_speed_active,
	input wire logic password_enable,
	input wire logic [63:0] full_password,
	input wire logic mission_active,
	input wire logic internal_busy,
	output logic mem_wr_en,
	output logic [15:0] mem_wr_addr,
	output logic [7:0] mem_wr_data,
	input wire logic mem_ready,
	output logic [7:0] target_address_low,
	output logic [7:0] target_address_high,
	output logic [7:0] ending_offset_status
);
	localparam logic [6:0] COPY_PACE = 7'(COPY_BYTE_CYC - 1);

	// One byte into the CRC, LSB first
	function automatic logic [15:0] crc16_byte(input logic [15:0] crc_in, input logic [7:0] d);
		logic [15:0] c;
		c = crc_in;
		for (int i = 0; i < 8; i++) begin
			if (c[0] ^ d[i]) begin
				c = (c >> 1) ^ CRC_POLY_REFL; // [RQ25]
			end else begin
				c = c >> 1;
			end
		end
		return c;
	endfunction : crc16_byte

	sdx_state_t state; // Command sequencer state
	logic [7:0] scratch [32]; // Scratchpad bytes
	logic [7:0] rx_sr; // Incoming bits, LSB first
	logic [2:0] rx_cnt; // Bits of the current byte
	logic [15:0] crc; // Running CRC
	logic [15:0] tx_sr; // Outgoing bits, bit 0 on the wire next
	logic [4:0] tx_left; // Bits left in the current word
	logic [4:0] ptr; // Scratchpad pointer for writes and reads
	logic [1:0] hdr; // Read preamble position, 3 = data phase
	logic [4:0] ending; // Ending offset field
	logic partial_byte_flag; // Trailing byte was incomplete
	logic copy_accepted_flag; // Last copy accepted
	logic addr_cnt; // Address byte number during a write
	logic [1:0] auth_cnt; // Authorisation byte number
	logic auth_ok; // Pattern matched so far
	logic [6:0] pw_cnt; // Password bits received
	logic [63:0] pw_sr; // Password being shifted in
	logic [4:0] cp_idx; // Next scratchpad byte to queue
	logic cp_queued; // All copy bytes queued
	logic [6:0] pace; // Cycles until the next byte may be written
	logic [7:0] rx_byte;
	logic rx_done;
	logic [4:0] rd_addr;
	logic [7:0] rd_data;
	logic [7:0] es_value;
	logic [15:0] target;
	logic reg_page;
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [23:0] fifo_out_data;
	logic tx_last;

	assign rx_byte = {slot_bit, rx_sr[7:1]};
	assign rx_done = ce && slot_write && (rx_cnt == 3'd7);
	assign target = {target_address_high, target_address_low};
	assign es_value = {copy_accepted_flag, 1'b0, partial_byte_flag, ending}; // [RQ2] [RQ4] [RQ5]
	assign reg_page = (target >= REG_PAGE_FIRST) && (target <= REG_PAGE_LAST);
	assign tx_last = ce && slot_read && (tx_left == 5'd1);
	// Read port serves the copy while copying, else the read stream
	assign rd_addr = (state == ST_COPY) ? cp_idx : ((hdr == 2'd3) ? ptr + 5'd1 : ptr);
	assign rd_data = scratch[rd_addr];
	assign fifo_in_valid = (state == ST_COPY) && !cp_queued;
	// Mission sampling owns the memory while busy
	assign fifo_out_ready = fifo_out_valid && (pace == '0) && !internal_busy && mem_ready; // [RQ23]

	// Copy FIFO between scratchpad and memory port
	sdx_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.sys_clk(sys_clk),
		.rst(rst),
		.ce(ce),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data({target[15:5], cp_idx, rd_data}), // [RQ19]
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	// Bit assembly; a bus reset outside a copy restarts byte framing
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rx_sr <= '0;
			rx_cnt <= '0;
		end else if (ce) begin
			if (bus_reset && state != ST_COPY) begin
				rx_cnt <= '0;
			end else if (slot_write) begin
				rx_sr <= rx_byte;
				rx_cnt <= rx_cnt + 3'd1;
			end
		end
	end

	// Scratchpad storage, whole bytes only
	always_ff @(posedge sys_clk) begin
		if (ce && rx_done && state == ST_WS_DATA) begin
			scratch[ptr] <= rx_byte; // [RQ8]
		end
	end

	// Speed follows the select; standard after reset
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			fast_speed_active <= 1'b0;
		end else if (ce) begin
			fast_speed_active <= fast_speed_select; // [RQ22]
		end
	end

	// Memory write port, paced to one byte per copy time
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mem_wr_en <= 1'b0;
			mem_wr_addr <= '0;
			mem_wr_data <= '0;
			pace <= '0;
		end else if (ce) begin
			mem_wr_en <= fifo_out_ready;
			if (fifo_out_ready) begin
				mem_wr_addr <= fifo_out_data[23:8];
				mem_wr_data <= fifo_out_data[7:0];
				pace <= COPY_PACE; // [RQ18]
			end else if (pace != '0) begin
				pace <= pace - 7'd1;
			end
		end
	end

	// Command sequencer with address, status, CRC and transmit registers
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state <= ST_CMD;
			target_address_low <= TA_RESET;
			target_address_high <= TA_RESET;
			ending <= ENDING_RESET;
			partial_byte_flag <= 1'b0;
			copy_accepted_flag <= 1'b0;
			crc <= CRC_CLEAR;
			tx_sr <= TX_ONES;
			tx_left <= '0;
			ptr <= '0;
			hdr <= '0;
			addr_cnt <= 1'b0;
			auth_cnt <= '0;
			auth_ok <= 1'b0;
			pw_cnt <= '0;
			pw_sr <= '0;
			cp_idx <= '0;
			cp_queued <= 1'b0;
		end else if (ce) begin
			if (bus_reset && state != ST_COPY) begin
				// Reset pulse ends any command except a running copy
				if (state == ST_WS_DATA && rx_cnt != 3'd0) begin
					partial_byte_flag <= 1'b1; // [RQ9] [RQ4]
				end
				state <= ST_CMD;
				tx_sr <= TX_ONES;
			end else begin
				unique case (state)
					ST_CMD: begin
						if (rx_done) begin
							crc <= crc16_byte(CRC_CLEAR, rx_byte); // [RQ10]
							if (rx_byte == CMD_WRITE_SCRATCH) begin
								state <= ST_WS_ADDR;
								addr_cnt <= 1'b0;
								copy_accepted_flag <= 1'b0; // [RQ7]
								partial_byte_flag <= 1'b0;
							end else if (rx_byte == CMD_READ_SCRATCH) begin
								// Preamble starts with the low address byte
								state <= ST_RS;
								hdr <= 2'd0;
								ptr <= target_address_low[4:0]; // [RQ6]
								tx_sr <= {8'hFF, target_address_low}; // [RQ11]
								tx_left <= 5'd8;
								crc <= crc16_byte(crc16_byte(CRC_CLEAR, rx_byte),
									target_address_low);
							end else if (rx_byte == CMD_COPY_SCRATCH) begin
								state <= ST_CP_AUTH;
								auth_cnt <= '0;
								auth_ok <= 1'b1;
							end else begin
								// Other commands belong to other blocks
								state <= ST_SILENT;
							end
						end
					end
					ST_WS_ADDR: begin
						if (rx_done) begin
							crc <= crc16_byte(crc, rx_byte); // [RQ10]
							if (!addr_cnt) begin
								target_address_low <= rx_byte; // [RQ1]
								addr_cnt <= 1'b1;
							end else begin
								target_address_high <= rx_byte; // [RQ1]
								ptr <= target_address_low[4:0]; // [RQ6]
								ending <= target_address_low[4:0];
								state <= ST_WS_DATA;
							end
						end
					end
					ST_WS_DATA: begin
						if (rx_done) begin
							crc <= crc16_byte(crc, rx_byte); // [RQ10]
							ending <= ptr; // [RQ2]
							ptr <= ptr + 5'd1;
							if (ptr == ENDING_FULL) begin
								// Scratchpad full: offer the inverted CRC
								tx_sr <= ~crc16_byte(crc, rx_byte); // [RQ10]
								tx_left <= 5'd16;
								state <= ST_WS_CRC;
							end
						end
					end
					ST_WS_CRC, ST_RS_CRC: begin
						if (ce && slot_read) begin
							tx_sr <= {1'b1, tx_sr[15:1]};
							tx_left <= tx_left - 5'd1;
							if (tx_last) begin
								tx_sr <= TX_ONES; // [RQ13]
								state <= ST_ONES;
							end
						end
					end
					ST_RS: begin
						if (ce && slot_read) begin
							tx_sr <= {1'b1, tx_sr[15:1]};
							tx_left <= tx_left - 5'd1;
							if (tx_last) begin
								tx_left <= 5'd8;
								if (hdr == 2'd0) begin
									tx_sr <= {8'hFF, target_address_high};
									crc <= crc16_byte(crc, target_address_high);
									hdr <= 2'd1;
								end else if (hdr == 2'd1) begin
									tx_sr <= {8'hFF, es_value};
									crc <= crc16_byte(crc, es_value);
									hdr <= 2'd2;
								end else if (hdr == 2'd2) begin
									tx_sr <= {8'hFF, rd_data};
									crc <= crc16_byte(crc, rd_data);
									hdr <= 2'd3;
								end else if (ptr == ENDING_FULL) begin
									tx_sr <= ~crc; // [RQ12]
									tx_left <= 5'd16;
									state <= ST_RS_CRC;
								end else begin
									tx_sr <= {8'hFF, rd_data};
									crc <= crc16_byte(crc, rd_data);
									ptr <= ptr + 5'd1;
								end
							end
						end
					end
					ST_CP_AUTH: begin
						if (rx_done) begin
							// Pattern must equal low, high, status in order
							if ((auth_cnt == 2'd0 && rx_byte != target_address_low) ||
								(auth_cnt == 2'd1 && rx_byte != target_address_high) ||
								(auth_cnt == 2'd2 && rx_byte != es_value)) begin
								auth_ok <= 1'b0; // [RQ14]
							end
							auth_cnt <= auth_cnt + 2'd1;
							if (auth_cnt == 2'd2) begin
								pw_cnt <= '0;
								state <= ST_CP_PW;
							end
						end
					end
					ST_CP_PW: begin
						if (ce && slot_write) begin
							// Bit 0 arrives first and ends up at the bottom
							pw_sr <= {slot_bit, pw_sr[63:1]}; // [RQ24]
							pw_cnt <= pw_cnt + 7'd1;
							if (pw_cnt == 7'(PW_BITS - 1)) begin
								if (password_enable && {slot_bit, pw_sr[63:1]} != full_password) begin
									state <= ST_SILENT; // [RQ15]
								end else if (auth_ok && ending == ENDING_FULL && // [RQ3]
									!(mission_active && reg_page)) begin // [RQ20] [RQ21]
									copy_accepted_flag <= 1'b1; // [RQ16] [RQ7]
									cp_idx <= target_address_low[4:0]; // [RQ19]
									cp_queued <= 1'b0;
									state <= ST_COPY;
								end else begin
									state <= ST_SILENT;
								end
							end
						end
					end
					ST_COPY: begin
						if (fifo_in_valid && fifo_in_ready) begin
							cp_idx <= cp_idx + 5'd1;
							if (cp_idx == ending) begin
								cp_queued <= 1'b1; // [RQ19]
							end
						end
						// Done once the last byte has had its full write time
						if (cp_queued && !fifo_out_valid && pace == '0 && !mem_wr_en) begin
							tx_sr <= TX_ALTERNATE; // [RQ17]
							state <= ST_ALT;
						end
					end
					ST_ALT: begin
						if (ce && slot_read) begin
							tx_sr <= {tx_sr[0], tx_sr[15:1]}; // [RQ17]
						end
					end
					ST_ONES, ST_SILENT: begin
						tx_sr <= TX_ONES; // [RQ13] [RQ15]
					end
					default: begin
						state <= ST_SILENT;
					end
				endcase
			end
		end
	end

	// Transmit bit and visible status, all from flip-flops
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			tx_bit <= 1'b1;
			reset_blocked <= 1'b0;
			ending_offset_status <= '0;
		end else if (ce) begin
			tx_bit <= tx_sr[0];
			reset_blocked <= (state == ST_COPY); // [RQ18]
			ending_offset_status <= es_value; // [RQ5]
		end
	end
endmodule : sdx_cmd

// ===== rtl/sdx_pkg.sv
/*
 * Shared constants and types of the scratchpad write/verify/copy command logic.
 * Assumes a bit-slot engine that turns bus time slots into same-clock pulses.
 */
package sdx_pkg;
	// Command codes
	localparam logic [7:0] CMD_WRITE_SCRATCH = 8'h0F;
	localparam logic [7:0] CMD_READ_SCRATCH = 8'hAA;
	localparam logic [7:0] CMD_COPY_SCRATCH = 8'h99;
	// Ending offset / status field positions
	localparam int ES_PARTIAL_BIT = 5;
	localparam int ES_ZERO_BIT = 6;
	localparam int ES_ACCEPT_BIT = 7;
	localparam logic [4:0] ENDING_FULL = 5'h1F;
	// Register values after reset
	localparam logic [7:0] TA_RESET = 8'h00;
	localparam logic [4:0] ENDING_RESET = 5'h00;
	// CRC-16, x^16+x^15+x^2+1, reflected form for LSB-first shifting
	localparam logic [15:0] CRC_POLY_REFL = 16'hA001;
	localparam logic [15:0] CRC_CLEAR = 16'h0000;
	// Transmit patterns
	localparam logic [15:0] TX_ONES = 16'hFFFF;
	localparam logic [15:0] TX_ALTERNATE = 16'h5555;
	localparam int PW_BITS = 64;
	// Register pages, write protected during a mission
	localparam logic [15:0] REG_PAGE_FIRST = 16'h0200;
	localparam logic [15:0] REG_PAGE_LAST = 16'h023F;
	// Timing: 40 MHz clock, 2 us per copied byte
	localparam int CLK_PERIOD_PS = 25000;
	localparam int COPY_BYTE_PS = 2000000;
	localparam int COPY_BYTE_CYC = (COPY_BYTE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// Copy FIFO shape: 16-bit address plus 8-bit data, 16 words
	localparam int FIFO_WIDTH = 24;
	localparam int FIFO_DEPTH = 16;

	typedef enum logic [3:0] {
		ST_CMD = 4'b0000,
		ST_WS_ADDR = 4'b0001,
		ST_WS_DATA = 4'b0010,
		ST_WS_CRC = 4'b0011,
		ST_RS = 4'b0100,
		ST_RS_CRC = 4'b0101,
		ST_ONES = 4'b0110,
		ST_CP_AUTH = 4'b0111,
		ST_CP_PW = 4'b1000,
		ST_COPY = 4'b1001,
		ST_ALT = 4'b1010,
		ST_SILENT = 4'b1011
	} sdx_state_t;
endpackage : sdx_pkg

// ===== tb/sdx_cmd_properties.sv
/*
 * Port checker for the scratchpad command block, bound into sdx_cmd.
 * Assumes one rising-edge clock and a synchronous active-high reset.
 */
`timescale 1ns/10ps
module sdx_cmd_props
	import sdx_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic reset_blocked,
	input wire logic fast_speed_select,
	input wire logic fast_speed_active,
	input wire logic mission_active,
	input wire logic internal_busy,
	input wire logic mem_wr_en,
	input wire logic [15:0] mem_wr_addr,
	input wire logic [7:0] target_address_low,
	input wire logic [7:0] target_address_high,
	input wire logic [7:0] ending_offset_status
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// Cycles since the last memory write; saturates so idle time never wraps
	logic [7:0] gap;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			gap <= 8'hFF;
		end else if (mem_wr_en) begin
			gap <= 8'h00;
		end else if (gap != 8'hFF) begin
			gap <= gap + 8'h01;
		end
	end
	// A copy begins when the reset guard rises
	sequence s_copy_start;
		$rose(reset_blocked);
	endsequence
	property p_zero_bit;
		ending_offset_status[ES_ZERO_BIT] == 1'b0;
	endproperty
	a_zero_bit: assert property (p_zero_bit) else $error("status bit six not zero");
	property p_full_before_copy;
		s_copy_start |-> ending_offset_status[4:0] == ENDING_FULL;
	endproperty
	a_full_before_copy: assert property (p_full_before_copy)
		else $error("copy started with short ending offset");
	property p_accept;
		s_copy_start |-> ##[0:3] ending_offset_status[ES_ACCEPT_BIT];
	endproperty
	a_accept: assert property (p_accept) else $error("accepted flag missing");
	property p_wr_in_copy;
		mem_wr_en |-> reset_blocked || $past(reset_blocked);
	endproperty
	a_wr_in_copy: assert property (p_wr_in_copy) else $error("write outside copy");
	property p_spacing;
		mem_wr_en |-> gap >= 8'(COPY_BYTE_CYC - 1);
	endproperty
	a_spacing: assert property (p_spacing) else $error("copy bytes too close");
	property p_page;
		mem_wr_en |-> mem_wr_addr[15:5] == {target_address_high, target_address_low[7:5]}
			&& mem_wr_addr[4:0] >= target_address_low[4:0];
	endproperty
	a_page: assert property (p_page) else $error("copy address outside range");
	property p_mission;
		mem_wr_en && mission_active |->
			!(mem_wr_addr >= REG_PAGE_FIRST && mem_wr_addr <= REG_PAGE_LAST);
	endproperty
	a_mission: assert property (p_mission) else $error("register page written");
	// A write launched while sampling owned the memory would collide with it
	property p_busy_yield;
		mem_wr_en |-> !$past(internal_busy);
	endproperty
	a_busy_yield: assert property (p_busy_yield) else $error("copy write during sampling");
	property p_speed;
		fast_speed_select ##1 fast_speed_select |-> fast_speed_active;
	endproperty
	a_speed: assert property (p_speed) else $error("fast speed not taken");
endmodule : sdx_cmd_props

bind sdx_cmd sdx_cmd_props u_props (.sys_clk, .rst, .reset_blocked, .fast_speed_select,
	.fast_speed_active, .mission_active, .internal_busy, .mem_wr_en, .mem_wr_addr,
	.target_address_low,
	.target_address_high, .ending_offset_status);

// ===== tb/sdx_master_model.sv
/*
 * Behavioural bus master: write, read and reset slot pulses.
 * Assumes the bench calls its tasks; pulses change at the falling edge.
 */
`timescale 1ns/10ps
module sdx_master_model (
	input wire logic sys_clk,
	input wire logic tx_bit,
	output logic slot_write,
	output logic slot_bit,
	output logic slot_read,
	output logic bus_reset
);
	// Idle bus at time zero
	initial begin
		slot_write = 1'b0;
		slot_bit = 1'b1;
		slot_read = 1'b0;
		bus_reset = 1'b0;
	end
	// One slot: 0 write, 1 read, 2 reset; two quiet cycles let the reply land
	task automatic pulse(input int kind, input logic b, output logic got);
		@(negedge sys_clk);
		got = tx_bit;
		slot_write = (kind == 0);
		slot_read = (kind == 1);
		bus_reset = (kind == 2);
		slot_bit = b;
		@(negedge sys_clk);
		slot_write = 1'b0;
		slot_read = 1'b0;
		bus_reset = 1'b0;
		slot_bit = ~b; // Released line must not echo the old bit
		repeat (2) @(negedge sys_clk);
	endtask : pulse
	// Bits go out least significant first, password included
	task automatic wr_bits(input int n, input logic [63:0] v);
		logic g;
		for (int i = 0; i < n; i++) begin
			pulse(0, v[i], g);
		end
	endtask : wr_bits
	// Read slots gather bits least significant first
	task automatic rd_bits(input int n, output logic [15:0] v);
		v = 16'hFFFF;
		for (int i = 0; i < n; i++) begin
			pulse(1, 1'b1, v[i]);
		end
	endtask : rd_bits
endmodule : sdx_master_model

// ===== tb/tb_scratchpad_write_verify_copy.sv
/*
 * Self-checking bench for sdx_cmd: write, read, copy, refusals, partial byte.
 * Assumes the master model for slots and a captured memory write port.
 */
`timescale 1ns/10ps
module tb_scratchpad_write_verify_copy import sdx_pkg::*;;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic password_enable = 1'b0;
	logic mission_active = 1'b0;
	logic internal_busy = 1'b0;
	logic mem_ready = 1'b1;
	logic fast_speed_select = 1'b0;
	logic [63:0] full_password = 64'h0123_4567_89AB_CDEF;
	logic slot_write, slot_bit, slot_read, bus_reset, tx_bit, reset_blocked;
	logic fast_speed_active, mem_wr_en;
	logic [15:0] mem_wr_addr, crc, v;
	logic [7:0] mem_wr_data, target_address_low, target_address_high, ending_offset_status;
	logic [7:0] lo, hi, es;
	logic [15:0] wa[$]; // Captured write addresses
	logic [7:0] wd[$]; // Captured write data
	int n_errors = 0;
	int comparisons = 0;
	always #12.5 sys_clk = ~sys_clk;
	sdx_cmd u_dut (.sys_clk, .rst, .ce(1'b1), .slot_write, .slot_bit, .slot_read,
		.bus_reset, .tx_bit, .reset_blocked, .fast_speed_select, .fast_speed_active,
		.password_enable, .full_password, .mission_active, .internal_busy, .mem_wr_en,
		.mem_wr_addr, .mem_wr_data, .mem_ready, .target_address_low,
		.target_address_high, .ending_offset_status);
	sdx_master_model u_master (.sys_clk, .tx_bit, .slot_write, .slot_bit, .slot_read,
		.bus_reset);
	// Memory side: record every write pulse, sampled mid-cycle where it has settled
	always @(negedge sys_clk) begin
		if (mem_wr_en === 1'b1) begin
			wa.push_back(mem_wr_addr);
			wd.push_back(mem_wr_data);
		end
	end
	task tally_and_finish;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : tally_and_finish
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Reflected CRC-16 step, one byte least significant bit first
	function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			c = (c[0] ^ b[i]) ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
		end
		return c;
	endfunction : crc8
	task brst;
		u_master.pulse(2, 1'b0, v[0]);
		crc = CRC_CLEAR;
		wa.delete();
		wd.delete();
	endtask : brst
	task tx(input logic [7:0] b);
		u_master.wr_bits(8, {56'h0, b});
		crc = crc8(crc, b);
	endtask : tx
	task rx8(output logic [7:0] b);
		u_master.rd_bits(8, v);
		b = v[7:0];
		crc = crc8(crc, b);
	endtask : rx8
	task rx16(input string nm, input logic [15:0] e);
		u_master.rd_bits(16, v);
		chk(nm, e, v);
	endtask : rx16
	task wsp(input logic [15:0] a, input int n);
		brst();
		tx(CMD_WRITE_SCRATCH);
		tx(a[7:0]);
		tx(a[15:8]);
		for (int k = 0; k < n; k++) begin
			tx(8'hA0 + 8'(k));
		end
	endtask : wsp
	task cpy(input logic [7:0] l, input logic [7:0] h, input logic [7:0] s,
		input logic [63:0] pw);
		brst();
		tx(CMD_COPY_SCRATCH);
		tx(l);
		tx(h);
		tx(s);
		u_master.wr_bits(64, pw);
	endtask : cpy
	// Bounded wait on the copy guard
	task wblk(input logic l);
		int i;
		for (i = 0; i < 4000 && reset_blocked !== l; i++) begin
			@(negedge sys_clk);
		end
		if (i == 4000) begin
			$display("[FAIL] reset_blocked expected %b seen %b", l, reset_blocked);
			n_errors++;
			tally_and_finish();
		end
	endtask : wblk
	initial begin
		repeat (6) @(negedge sys_clk);
		rst = 1'b0;
		chk("es_rst", 16'h0000, 16'(ending_offset_status));
		chk("fast_off", 16'h0000, 16'(fast_speed_active));
		fast_speed_select = 1'b1;
		repeat (3) @(negedge sys_clk);
		chk("fast_on", 16'h0001, 16'(fast_speed_active));
		fast_speed_select = 1'b0;
		// Write four bytes into the top of the scratchpad
		wsp(16'h013C, 4);
		rx16("wcrc", ~crc);
		chk("ta", 16'h013C, {target_address_high, target_address_low});
		chk("es", 16'h001F, 16'(ending_offset_status));
		// Read back preamble, data, CRC, then ones
		brst();
		tx(CMD_READ_SCRATCH);
		rx8(lo);
		rx8(hi);
		rx8(es);
		chk("rd_ta", 16'h013C, {hi, lo});
		chk("rd_es", 16'h001F, 16'(es));
		for (int k = 0; k < 4; k++) begin
			rx8(es);
			chk("rd_dat", 16'(8'hA0 + 8'(k)), 16'(es));
		end
		rx16("rcrc", ~crc);
		rx16("rones", TX_ONES);
		// Wrong password is refused
		password_enable = 1'b1;
		cpy(8'h3C, 8'h01, 8'h1F, ~full_password);
		rx16("badpw", TX_ONES);
		chk("badpw_wr", 16'h0000, 16'(wa.size()));
		// Good copy with the memory stalled and a reset sent mid-copy
		mem_ready = 1'b0;
		internal_busy = 1'b1;
		cpy(8'h3C, 8'h01, 8'h1F, full_password);
		wblk(1'b1);
		u_master.pulse(2, 1'b0, v[0]);
		repeat (100) @(negedge sys_clk);
		mem_ready = 1'b1;
		// Sampling alone must still hold the copy writes back
		repeat (100) @(negedge sys_clk);
		chk("busy_hold", 16'h0000, 16'(wa.size()));
		internal_busy = 1'b0;
		wblk(1'b0);
		chk("aa", 16'h009F, 16'(ending_offset_status));
		chk("nwr", 16'h0004, 16'(wa.size()));
		for (int k = 0; k < 4; k++) begin
			chk("waddr", 16'h013C + 16'(k), wa[k]);
			chk("wdata", 16'(8'hA0 + 8'(k)), 16'(wd[k]));
		end
		rx16("alt", TX_ALTERNATE);
		// Mission: write still works, register-page copy refused
		mission_active = 1'b1;
		wsp(16'h0220, 32);
		chk("aa_clr", 16'h001F, 16'(ending_offset_status));
		cpy(8'h20, 8'h02, 8'h1F, full_password);
		rx16("mis", TX_ONES);
		chk("mis_es", 16'h001F, 16'(ending_offset_status));
		chk("mis_wr", 16'h0000, 16'(wa.size()));
		// Checking off: any password copies a full page
		mission_active = 1'b0;
		password_enable = 1'b0;
		wsp(16'h0040, 32);
		cpy(8'h40, 8'h00, 8'h1F, 64'h0);
		wblk(1'b1);
		wblk(1'b0);
		chk("nopw_wr", 16'h0020, 16'(wa.size()));
		// Mission on: data pages still take a copy; pattern now carries the set flag
		mission_active = 1'b1;
		cpy(8'h40, 8'h00, 8'h9F, 64'h0);
		wblk(1'b1);
		wblk(1'b0);
		chk("mis_data_wr", 16'h0020, 16'(wa.size()));
		mission_active = 1'b0;
		// Trailing three bits dropped, then a short copy is refused
		brst();
		tx(CMD_WRITE_SCRATCH);
		tx(8'h00);
		tx(8'h00);
		tx(8'h11);
		tx(8'h22);
		u_master.wr_bits(3, 64'h5);
		brst();
		chk("pf", 16'h0021, 16'(ending_offset_status));
		cpy(8'h00, 8'h00, 8'h21, 64'h0);
		rx16("short", TX_ONES);
		chk("short_wr", 16'h0000, 16'(wa.size()));
		tally_and_finish();
	end
endmodule : tb_scratchpad_write_verify_copy
